// ### include/prpm_consts.vh
// Constants for the peripheral request pin mux
`ifndef PRPM_CONSTS_VH
`define PRPM_CONSTS_VH
`define PRPM_ADDR_PM_POL 8'h40
`define PRPM_ADDR_CFG_A0 8'ha0
`define PRPM_ADDR_CFG_A1 8'ha1
`define PRPM_ADDR_CORE 8'hf0
`define PRPM_ADDR_STAT 8'hf4
`define PRPM_ADDR_REQ 8'hf8
`define PRPM_POL_WAKE1_BIT 1
`define PRPM_POL_WAKE2_BIT 2
`define PRPM_POL_BATTERY_LOW_IN_BIT 4
`define PRPM_POL_VLOWBAT_BIT 5
`define PRPM_A0_ACKPMU_BIT 3
`define PRPM_A0_LOCAL_BUS_GRANT_N_BIT 5
`define PRPM_A1_WAKEMUX_BIT 5
`define PRPM_RST_PM_POL 8'h00
`define PRPM_RST_CFG_A0 8'h00
`define PRPM_RST_CFG_A1 8'h00
`define PRPM_RST_CORE 8'h00
`define PRPM_SLOT_NS 100
`define PRPM_CLK_MHZ 20
`define PRPM_SLOT_CYC ((`PRPM_SLOT_NS * `PRPM_CLK_MHZ) / 1000)
`define PRPM_ACK_NONE 3'h4
`endif

// ### tb/prpm_chk.sv
// Port checker for the pin mux
`timescale 1ns/1ns
`default_nettype none
module prpm_chk #(parameter SLOT_CYC = 2) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] req_mux_sel,
  input wire logic mem_ctl_disable_strap,
  input wire logic [7:0] dma_ack_active,
  input wire logic [2:0] mem_ctl_ack,
  input wire logic mem_ctl_ack_oe_n,
  input wire logic dma_bus_owned,
  input wire logic address_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] sel_reg;
  int dwell_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= 2'h0;
      dwell_reg <= -1;
    end else begin
      sel_reg <= req_mux_sel;
      dwell_reg <= (req_mux_sel != sel_reg) ? 0 : dwell_reg + 1;
    end
  end
  sequence s_strap_on;
    mem_ctl_disable_strap [*4];
  endsequence
  sequence s_strap_off;
    !mem_ctl_disable_strap [*4];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_SEL_STEP: assert property (req_mux_sel != sel_reg |-> req_mux_sel == sel_reg + 2'h1)
    else $error("select skipped a slot");
  AST_SEL_DWELL: assert property (req_mux_sel != sel_reg |-> dwell_reg == SLOT_CYC - 1)
    else $error("slot length wrong");
  AST_STRAP_ON: assert property (s_strap_on |-> !mem_ctl_ack_oe_n)
    else $error("encoded ack not driven");
  AST_STRAP_OFF: assert property (s_strap_off |-> mem_ctl_ack_oe_n)
    else $error("encoded ack driven on memory pins");
  AST_ACK_SKIP4: assert property (!mem_ctl_ack_oe_n && $past(dma_ack_active) == 8'h10 |-> mem_ctl_ack == 3'h4)
    else $error("channel 4 acknowledged");
  AST_ACK_CH2: assert property (!mem_ctl_ack_oe_n && $past(dma_ack_active) == 8'h14 |-> mem_ctl_ack == 3'h2)
    else $error("channel 2 code wrong");
  AST_AEN: assert property (1'b1 |=> address_enable == $past(dma_bus_owned))
    else $error("address enable wrong");
endmodule // prpm_chk
bind prpm_pin_mux prpm_chk #(.SLOT_CYC(SLOT_CYC)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hreadyout(hreadyout), .hresp(hresp), .req_mux_sel(req_mux_sel),
  .mem_ctl_disable_strap(mem_ctl_disable_strap), .dma_ack_active(dma_ack_active),
  .mem_ctl_ack(mem_ctl_ack), .mem_ctl_ack_oe_n(mem_ctl_ack_oe_n),
  .dma_bus_owned(dma_bus_owned), .address_enable(address_enable));
`default_nettype wire

// ### tb/prpm_pin_mux_tb.sv
// Testbench for the pin mux
`timescale 1ns/1ns
`default_nettype none
module prpm_pin_mux_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, req_mux_sel;
  logic [15:0] irq_src = 16'h0, irq_out;
  logic [7:0] drq_src = 8'h0, drq_out, dma_ack_active = 8'h0;
  logic [3:0] req_mux_in;
  logic shared_pin = 1'b0, bat_lo = 1'b0, bat_vlo = 1'b0, wk1 = 1'b0, wk2 = 1'b0;
  logic strap = 1'b0, owned = 1'b0, tc = 1'b0, ide_rd = 1'b0, dbe_n = 1'b1, local_bus_grant_n_n = 1'b1;
  logic wake_mux, wake_mpx, bat_lo_o, bat_vlo_o, wk1_o, wk2_o, ack2_n, mem_oe_n, pmu_oe_n;
  logic tcr, aen;
  logic npi = 1'b0, m386 = 1'b0;
  logic [2:0] mem_ack, pmu_ack;
  int num_errors = 0, n_compared = 0, cyc = 0;
  prpm_pin_mux #(.SLOT_CYC(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .req_mux_in(req_mux_in), .shared_req_pin(shared_pin),
    .battery_low_in(bat_lo), .battery_very_low_in(bat_vlo), .wake_source_one(wk1),
    .wake_source_two(wk2), .mem_ctl_disable_strap(strap), .dma_ack_active(dma_ack_active),
    .dma_bus_owned(owned), .terminal_count(tc), .ide_read(ide_rd),
    .data_buffer_enable_n(dbe_n), .coprocessor_interrupt(npi), .local_bus_grant_n(local_bus_grant_n_n),
    .mode_386(m386), .req_mux_sel(req_mux_sel), .irq_out(irq_out), .drq_out(drq_out),
    .wake_event_mux_in(wake_mux), .wake_multiplex_in(wake_mpx), .battery_low(bat_lo_o),
    .battery_very_low(bat_vlo_o), .wake_one(wk1_o), .wake_two(wk2_o),
    .dma_ack_ch2_n(ack2_n), .mem_ctl_ack(mem_ack), .mem_ctl_ack_oe_n(mem_oe_n),
    .pmu_ack(pmu_ack), .pmu_ack_oe_n(pmu_oe_n), .terminal_count_ide_read(tcr),
    .address_enable(aen));
  prpm_req_src u_src (.req_mux_sel(req_mux_sel), .irq_src(irq_src), .drq_src(drq_src),
    .req_mux_in(req_mux_in));
  always #25 core_clk = ~core_clk;
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_regs();
    rdchk(8'ha0, 32'h0);
    rdchk(8'h40, 32'h0);
    bus(1'b1, 8'h80, 32'hff);
    rdchk(8'h80, 32'h0);
    bus(1'b1, 8'h40, 32'h36);
    rdchk(8'h40, 32'h36);
  endtask
  task automatic t_slots();
    logic [15:0] p;
    logic [7:0] q;
    for (int i = 0; i < 2; i++) begin
      p = i ? 16'h5a3c : 16'ha5c3;
      q = i ? 8'h91 : 8'h6e;
      @(posedge core_clk);
      irq_src <= p;
      drq_src <= q;
      wt(12);
      chk(irq_out, p & 16'hd5da);
      chk(drq_out, q & 8'heb);
    end
  endtask
  task automatic t_share();
    chk({bat_lo_o, bat_vlo_o, wk1_o, wk2_o}, 4'hf);
    @(posedge core_clk);
    {shared_pin, bat_lo, bat_vlo, wk1, wk2} <= 5'h1f;
    wt(4);
    chk({bat_lo_o, bat_vlo_o, wk1_o, wk2_o}, 4'h0);
    chk({drq_out[2], wake_mux}, 2'h2);
    bus(1'b1, 8'ha1, 32'h20);
    wt(4);
    chk({drq_out[2], wake_mux}, 2'h1);
  endtask
  task automatic t_ack();
    @(posedge core_clk);
    strap <= 1'b1;
    dma_ack_active <= 8'h14;
    wt(5);
    chk({mem_oe_n, mem_ack, ack2_n, pmu_oe_n}, 6'h09);
    dma_ack_active <= 8'h10;
    wt(2);
    chk({mem_ack, ack2_n}, 4'h9);
    m386 <= 1'b1;
    npi <= 1'b0;
    wt(2);
    chk(ack2_n, 1'b0);
    bus(1'b1, 8'ha0, 32'h28);
    dma_ack_active <= 8'h90;
    local_bus_grant_n_n <= 1'b0;
    bat_vlo <= 1'b1;
    strap <= 1'b0;
    wt(5);
    chk({pmu_oe_n, pmu_ack, ack2_n, bat_vlo_o}, 6'h1c);
    chk(wake_mpx, 1'b1);
    chk(mem_oe_n, 1'b1);
  endtask
  task automatic t_misc();
    @(posedge core_clk);
    tc <= 1'b1;
    owned <= 1'b1;
    wt(2);
    chk({tcr, aen}, 2'h3);
    dbe_n <= 1'b0;
    ide_rd <= 1'b1;
    owned <= 1'b0;
    wt(2);
    chk(aen, 1'b0);
    chk(tcr, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_slots();
    t_share();
    t_ack();
    t_misc();
    end_of_test();
  end
endmodule // prpm_pin_mux_tb
`default_nettype wire

// ### tb/prpm_req_src.sv
// External request multiplexer model
`timescale 1ns/1ns
`default_nettype none
module prpm_req_src (
  input wire logic [1:0] req_mux_sel,
  input wire logic [15:0] irq_src,
  input wire logic [7:0] drq_src,
  output logic [3:0] req_mux_in
);
  always_comb begin
    case (req_mux_sel)
      2'h0: req_mux_in = {drq_src[1], irq_src[10], irq_src[6], irq_src[3]};
      2'h1: req_mux_in = {drq_src[3], drq_src[0], irq_src[8], irq_src[1]};
      2'h2: req_mux_in = {drq_src[6], drq_src[5], irq_src[4], irq_src[7]};
      default: req_mux_in = {drq_src[7], irq_src[15], irq_src[12], irq_src[14]};
    endcase
  end
endmodule // prpm_req_src
`default_nettype wire

// ### verilog/prpm_pin_mux.v
// Peripheral request pin mux with AHB-Lite configuration slave
// Contract
// - Slots of req_mux_in_3 yield DMA requests 1, 3, 6 and 7 in that order.
// - Slots of req_mux_in_2 yield IRQ10, DMA request 0, DMA request 5 and IRQ15.
// - Slots of req_mux_in_1 yield IRQ6, IRQ8, IRQ4 and IRQ12 in that order.
// - Slots of req_mux_in_0 yield IRQ3, IRQ1, IRQ7 and IRQ14 in that order.
// - A1h bit 5 low makes the shared pin the channel 2 request, high the wake mux input.
// - A0h bit 5 low drives channel 2 ack (or coprocessor interrupt in 386 mode), high grant.
// - Memory control pins carry the encoded ack only when the strap disables memory control.
// - A0h bit 3 high puts the encoded ack on the battery and wake pins.
// - After reset those pins are battery and wake inputs, A0h bit 3 low.
// - One output is terminal count, or IDE read when qualified by data buffer enable.
// - Low battery input polarity is set by 40h bit 4.
// - Very low battery polarity is set by 40h bit 5; with A0h bit 3 high it is the wake mux.
// - First wake source polarity is set by 40h bit 1.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "prpm_consts.vh"
module prpm_pin_mux #(
  parameter SLOT_CYC = `PRPM_SLOT_CYC
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [3:0] req_mux_in,
  input wire shared_req_pin,
  input wire battery_low_in,
  input wire battery_very_low_in,
  input wire wake_source_one,
  input wire wake_source_two,
  input wire mem_ctl_disable_strap,
  input wire [7:0] dma_ack_active,
  input wire dma_bus_owned,
  input wire terminal_count,
  input wire ide_read,
  input wire data_buffer_enable_n,
  input wire coprocessor_interrupt,
  input wire local_bus_grant_n,
  input wire mode_386,
  output reg [1:0] req_mux_sel,
  output reg [15:0] irq_out,
  output reg [7:0] drq_out,
  output reg wake_event_mux_in,
  output reg wake_multiplex_in,
  output reg battery_low,
  output reg battery_very_low,
  output reg wake_one,
  output reg wake_two,
  output reg dma_ack_ch2_n,
  output reg [2:0] mem_ctl_ack,
  output reg mem_ctl_ack_oe_n,
  output reg [2:0] pmu_ack,
  output reg pmu_ack_oe_n,
  output reg terminal_count_ide_read,
  output reg address_enable
);
  reg [7:0] pm_pol_reg;
  reg [7:0] cfg_a0_reg;
  reg [7:0] cfg_a1_reg;
  reg [7:0] core_reg;
  reg [1:0] s1_reg;
  reg [1:0] s2_reg;
  reg [3:0] req_s1_reg;
  reg [3:0] req_s2_reg;
  reg [4:0] pin_s1_reg;
  reg [4:0] pin_s2_reg;
  reg strap_s1_reg;
  reg strap_s2_reg;
  reg [15:0] cnt_reg;
  reg [1:0] phase_reg;
  reg wr_pend_reg;
  reg [7:0] addr_reg;
  reg [2:0] ack_code;
  reg [7:0] rd_data;
  wire ack_any;
  wire addr_ok;
  wire ap_valid;
  wire [7:0] haddr8;
  integer i;

  assign haddr8 = haddr[7:0];
  assign ap_valid = hsel & hready & htrans[1];
  assign ack_any = |dma_ack_active;

  // Register address decode
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `PRPM_ADDR_PM_POL) | (a == `PRPM_ADDR_CFG_A0) |
        (a == `PRPM_ADDR_CFG_A1) | (a == `PRPM_ADDR_CORE) |
        (a == `PRPM_ADDR_STAT) | (a == `PRPM_ADDR_REQ);
    end
  endfunction

  // Writable register decode
  function is_writable;
    input [7:0] a;
    begin
      is_writable = (a == `PRPM_ADDR_PM_POL) | (a == `PRPM_ADDR_CFG_A0) |
        (a == `PRPM_ADDR_CFG_A1) | (a == `PRPM_ADDR_CORE);
    end
  endfunction

  assign addr_ok = is_mapped(haddr8);

  always @* begin
    ack_code = `PRPM_ACK_NONE;
    for (i = 7; i >= 0; i = i - 1) begin
      if (dma_ack_active[i] && (i != 4)) begin
        ack_code = i[2:0];
      end
    end
  end

  // Decode on the address phase
  always @* begin
    case (haddr8)
      `PRPM_ADDR_PM_POL: rd_data = pm_pol_reg;
      `PRPM_ADDR_CFG_A0: rd_data = cfg_a0_reg;
      `PRPM_ADDR_CFG_A1: rd_data = cfg_a1_reg;
      `PRPM_ADDR_CORE: rd_data = core_reg;
      `PRPM_ADDR_STAT: rd_data = {3'h0, strap_s2_reg, ack_any, 1'b0, phase_reg};
      `PRPM_ADDR_REQ: rd_data = drq_out;
      default: rd_data = 8'h00;
    endcase
    // Forward a write still in its data phase
    if (wr_pend_reg && (addr_reg == haddr8) && is_writable(haddr8)) begin
      rd_data = hwdata[7:0];
    end
  end

  // Bus slave, zero wait states
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pm_pol_reg <= `PRPM_RST_PM_POL;
      cfg_a0_reg <= `PRPM_RST_CFG_A0;
      cfg_a1_reg <= `PRPM_RST_CFG_A1;
      core_reg <= `PRPM_RST_CORE;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= ap_valid & hwrite & addr_ok;
      if (ap_valid) begin
        addr_reg <= haddr8;
      end
      // Read data stands in the data phase
      if (ap_valid && !hwrite) begin
        hrdata <= {24'h0, rd_data};
      end
      if (wr_pend_reg) begin
        case (addr_reg)
          `PRPM_ADDR_PM_POL: pm_pol_reg <= hwdata[7:0];
          `PRPM_ADDR_CFG_A0: cfg_a0_reg <= hwdata[7:0];
          `PRPM_ADDR_CFG_A1: cfg_a1_reg <= hwdata[7:0];
          `PRPM_ADDR_CORE: core_reg <= hwdata[7:0];
          default: core_reg <= core_reg;
        endcase
      end
    end
  end

  // Input synchronisers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_reg <= 4'h0;
      req_s2_reg <= 4'h0;
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
    end else if (clk_en) begin
      req_s1_reg <= req_mux_in;
      req_s2_reg <= req_s1_reg;
      pin_s1_reg <= {shared_req_pin, battery_low_in, battery_very_low_in,
        wake_source_one, wake_source_two};
      pin_s2_reg <= pin_s1_reg;
      strap_s1_reg <= mem_ctl_disable_strap;
      strap_s2_reg <= strap_s1_reg;
      s1_reg <= phase_reg;
      // Second phase stage lines up with req_s2_reg
      s2_reg <= s1_reg;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0;
      phase_reg <= 2'h0;
      req_mux_sel <= 2'h0;
    end else if (clk_en) begin
      if (cnt_reg >= SLOT_CYC - 1) begin
        cnt_reg <= 16'h0;
        phase_reg <= phase_reg + 2'h1;
        req_mux_sel <= phase_reg + 2'h1;
      end else begin
        cnt_reg <= cnt_reg + 16'h1;
      end
    end
  end

  // Slot capture, sampled phase delayed to match sync
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 16'h0;
      drq_out <= 8'h0;
      wake_event_mux_in <= 1'b0;
      wake_multiplex_in <= 1'b0;
      battery_low <= 1'b0;
      battery_very_low <= 1'b0;
      wake_one <= 1'b0;
      wake_two <= 1'b0;
    end else if (clk_en) begin
      case (s2_reg)
        2'h0: begin
          drq_out[1] <= req_s2_reg[3];
          irq_out[10] <= req_s2_reg[2];
          irq_out[6] <= req_s2_reg[1];
          irq_out[3] <= req_s2_reg[0];
        end
        2'h1: begin
          drq_out[3] <= req_s2_reg[3];
          drq_out[0] <= req_s2_reg[2];
          irq_out[8] <= req_s2_reg[1];
          irq_out[1] <= req_s2_reg[0];
        end
        2'h2: begin
          drq_out[6] <= req_s2_reg[3];
          drq_out[5] <= req_s2_reg[2];
          irq_out[4] <= req_s2_reg[1];
          irq_out[7] <= req_s2_reg[0];
        end
        default: begin
          drq_out[7] <= req_s2_reg[3];
          irq_out[15] <= req_s2_reg[2];
          irq_out[12] <= req_s2_reg[1];
          irq_out[14] <= req_s2_reg[0];
        end
      endcase
      drq_out[2] <= cfg_a1_reg[`PRPM_A1_WAKEMUX_BIT] ? 1'b0 : pin_s2_reg[4];
      wake_event_mux_in <= cfg_a1_reg[`PRPM_A1_WAKEMUX_BIT] ? pin_s2_reg[4] : 1'b0;
      battery_low <= cfg_a0_reg[`PRPM_A0_ACKPMU_BIT] ? 1'b0 :
        pin_s2_reg[3] ^ pm_pol_reg[`PRPM_POL_BATTERY_LOW_IN_BIT];
      // Very low battery or wake mux
      battery_very_low <= cfg_a0_reg[`PRPM_A0_ACKPMU_BIT] ? 1'b0 :
        pin_s2_reg[2] ^ pm_pol_reg[`PRPM_POL_VLOWBAT_BIT];
      wake_multiplex_in <= cfg_a0_reg[`PRPM_A0_ACKPMU_BIT] ? pin_s2_reg[2] : 1'b0;
      wake_one <= cfg_a0_reg[`PRPM_A0_ACKPMU_BIT] ? 1'b0 :
        pin_s2_reg[1] ^ pm_pol_reg[`PRPM_POL_WAKE1_BIT];
      wake_two <= cfg_a0_reg[`PRPM_A0_ACKPMU_BIT] ? 1'b0 :
        pin_s2_reg[0] ^ pm_pol_reg[`PRPM_POL_WAKE2_BIT];
    end
  end

  // Output pins
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_ack_ch2_n <= 1'b1;
      mem_ctl_ack <= `PRPM_ACK_NONE;
      mem_ctl_ack_oe_n <= 1'b1;
      pmu_ack <= `PRPM_ACK_NONE;
      pmu_ack_oe_n <= 1'b1;
      terminal_count_ide_read <= 1'b0;
      address_enable <= 1'b0;
    end else if (clk_en) begin
      if (cfg_a0_reg[`PRPM_A0_LOCAL_BUS_GRANT_N_BIT]) begin
        dma_ack_ch2_n <= local_bus_grant_n;
      end else if (mode_386) begin
        dma_ack_ch2_n <= coprocessor_interrupt;
      end else begin
        dma_ack_ch2_n <= ~dma_ack_active[2];
      end
      // Ack on memory pins by strap
      mem_ctl_ack <= ack_code;
      mem_ctl_ack_oe_n <= ~strap_s2_reg;
      pmu_ack <= ack_code;
      pmu_ack_oe_n <= ~cfg_a0_reg[`PRPM_A0_ACKPMU_BIT];
      terminal_count_ide_read <= data_buffer_enable_n ? terminal_count : ~ide_read;
      address_enable <= dma_bus_owned;
    end
  end
endmodule // prpm_pin_mux
`default_nettype wire
